// file: core/smmc_pkg.sv
// constants, types and helpers for the stepper motion mode controller
// Function
// - fourteen operating modes, one chosen per profile
// - relative or absolute move to target position
// - internal reference run at minimum speed only
// - external reference run stops on switch
// - speed mode ramps start to maximum, holds
// - speed inputs change target speed on the fly
// - flag mode: speed, then latched-distance move
// - one step per external clock, given direction
// - clock-direction variants add reference runs
// - analog command sets speed and direction
// - analog level sets servo target position
// - analog level sets torque limit
// - answer only own address, up to 254
// - six inputs with selectable polarity
// - frame 8N1 at default 19200 baud
// - 50 kHz clock input, 25 kHz internal
package smmc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    localparam int unsigned CLK_HZ        = 32'h0131_2D00;
    localparam logic [15:0] STEP_MAX_HZ   = 16'h61A8;
    localparam int unsigned CD_MAX_HZ     = 32'h0000_C350;
    localparam logic [15:0] CD_MIN_GAP_CYC = 16'((CLK_HZ + CD_MAX_HZ - 32'h0000_0001) / CD_MAX_HZ);
    localparam int unsigned RAMP_TICK_US  = 32'h0000_03E8;
    localparam int unsigned RAMP_TICK_CYC = CLK_HZ / 32'h000F_4240 * RAMP_TICK_US;
    localparam int unsigned ACC_W         = 32'h0000_0018;
    localparam logic [15:0] HZ_SCALE      = 16'(64'h0000_0100_0000_0000 / 64'(CLK_HZ));
    localparam int unsigned BAUD_DEFAULT  = 32'h0000_4B00;
    localparam int unsigned BIT_CYC       = CLK_HZ / BAUD_DEFAULT;
    localparam logic [3:0]  FRAME_DATA_BITS = 4'h8;
    localparam logic [7:0]  ADDR_MIN      = 8'h01;
    localparam logic [7:0]  ADDR_MAX      = 8'hFE;
    localparam logic [11:0] JOY_DEAD      = 12'h040;
    localparam logic [15:0] ANALOG_HZ_GAIN = 16'h000C;
    localparam logic [4:0]  APOS_SHIFT    = 5'h04;
    localparam logic [11:0] TORQUE_FULL   = 12'hFFF;
    localparam logic [15:0] RST_HZ        = 16'h0000;
    localparam logic [31:0] RST_POS       = 32'h0000_0000;

    // input positions after polarity
    localparam int unsigned IN_EN    = 32'h0000_0000;
    localparam int unsigned IN_SEL   = 32'h0000_0001;
    localparam int unsigned IN_CDLIM = 32'h0000_0003;
    localparam int unsigned IN_TRIG  = 32'h0000_0004;
    localparam int unsigned IN_CDDIR = 32'h0000_0004;
    localparam int unsigned IN_SW    = 32'h0000_0005;

    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [3:0] {
        MD_REL      = 4'h0,
        MD_ABS      = 4'h1,
        MD_IREF     = 4'h2,
        MD_EREF     = 4'h3,
        MD_SPEED    = 4'h4,
        MD_FLAG     = 4'h5,
        MD_CD_LEFT  = 4'h6,
        MD_CD_RIGHT = 4'h7,
        MD_CD_IREF  = 4'h8,
        MD_CD_EREF  = 4'h9,
        MD_ANALOG   = 4'hA,
        MD_JOY      = 4'hB,
        MD_APOS     = 4'hC,
        MD_TORQUE   = 4'hD
    } smmc_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REF  = 2'b01,
        ST_RUN  = 2'b10,
        ST_POS  = 2'b11
    } smmc_state_e;

    typedef struct packed {
        smmc_mode_e         mode;
        logic [15:0]        start_hz;
        logic [15:0]        max_hz;
        logic [15:0]        ramp_hz;
        logic signed [31:0] target;
        logic               ref_dir;
        logic [5:0]         in_pol;
    } smmc_cfg_s;

    typedef struct packed {
        logic               busy;
        logic               ref_done;
        logic signed [31:0] position;
        logic [11:0]        torque_limit;
    } smmc_stat_s;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] clamp_hz(input logic [15:0] hz);
        clamp_hz = (hz > STEP_MAX_HZ) ? STEP_MAX_HZ : hz;
    endfunction

    function automatic logic [11:0] analog_mag(input logic signed [11:0] a);
        analog_mag = a[11] ? 12'(-a) : 12'(a);
    endfunction

endpackage

// file: core/smmc_input_pol.sv
// polarity correction for the six digital control inputs
`timescale 1ns/1ps
`default_nettype none
module smmc_input_pol
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic [5:0] raw,
    input  wire logic [5:0] pol,
    output var  logic [5:0] act
);
    logic [5:0] next_act;

    always_comb
    begin
        next_act = ~(raw ^ pol);
        if (!ce)
        begin
            next_act = act;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            act <= 6'h00;
        end
        else
        begin
            act <= next_act;
        end
    end
endmodule // smmc_input_pol
`default_nettype wire

// file: core/smmc_step_gen.sv
// phase accumulator that turns a rate in hertz into step pulses
`timescale 1ns/1ps
`default_nettype none
module smmc_step_gen
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [15:0] hz,
    output var  logic        step
);
    localparam int unsigned W = smmc_pkg::ACC_W;
    logic [W-1:0] acc;
    logic [W-1:0] next_acc;
    logic         next_step;
    logic [31:0]  prod;
    logic [W:0]   sum;

    always_comb
    begin
        prod      = 32'(smmc_pkg::clamp_hz(hz)) * 32'(smmc_pkg::HZ_SCALE);
        sum       = {1'b0, acc} + (W + 1)'(prod[31:16]);
        next_acc  = acc;
        next_step = 1'b0;
        if (ce && hz != smmc_pkg::RST_HZ)
        begin
            next_acc  = sum[W-1:0];
            next_step = sum[W];
        end
        else if (!ce)
        begin
            next_step = step;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            acc  <= '0;
            step <= 1'b0;
        end
        else
        begin
            acc  <= next_acc;
            step <= next_step;
        end
    end
endmodule // smmc_step_gen
`default_nettype wire

// file: core/smmc_top.sv
// motion mode controller: mode sequencing, ramps, position and step output
`timescale 1ns/1ps
`default_nettype none
module smmc_top
#(
    parameter int unsigned RAMP_TICK_CYC = smmc_pkg::RAMP_TICK_CYC
)
(
    input  wire logic                CLK_SYS,
    input  wire logic                SYS_RST,
    input  wire logic                CLK_EN,
    input  wire logic                START,
    input  wire logic                STOP,
    input  wire smmc_pkg::smmc_cfg_s CFG,
    input  wire logic [5:0]          IN_RAW,
    input  wire logic signed [11:0]  ANALOG_IN,
    input  wire logic [7:0]          NODE_ADDR,
    input  wire logic [7:0]          FRAME_ADDR,
    input  wire logic                FRAME_ADDR_VALID,
    output var  logic                STEP,
    output var  logic                DIR,
    output var  smmc_pkg::smmc_stat_s STATUS,
    output var  logic                ADDR_MATCH
);
    ////////////////////////////////////////////////////////////////////////////
    smmc_pkg::smmc_state_e state;
    smmc_pkg::smmc_state_e next_state;
    logic signed [31:0]    pos;
    logic signed [31:0]    next_pos;
    logic signed [31:0]    tgt;
    logic signed [31:0]    next_tgt;
    logic [15:0]           cur_hz;
    logic [15:0]           next_hz;
    logic [31:0]           tick;
    logic [31:0]           next_tick;
    logic [15:0]           gap;
    logic [15:0]           next_gap;
    logic                  next_dir;
    logic                  next_step;
    logic                  ref_done;
    logic                  next_ref_done;
    logic                  cd_clk_q;
    logic                  trig_q;
    logic [11:0]           torque;
    logic [11:0]           next_torque;
    logic                  next_match;
    logic [5:0]            act;
    logic                  gen_step;
    logic [15:0]           gen_hz;
    logic                  want;
    logic                  ramp_now;
    logic                  is_cd;
    logic                  no_ramp;
    logic [11:0]           mag;
    logic [15:0]           run_hz;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] ramp_to(input logic [15:0] cur, input logic [15:0] goal,
                                            input logic [15:0] inc);
        logic [16:0] up;
        logic [16:0] dn;
        up = {1'b0, cur} + {1'b0, inc};
        dn = {1'b0, cur} - {1'b0, inc};
        if (cur < goal)
        begin
            ramp_to = (up[15:0] > goal || up[16]) ? goal : up[15:0];
        end
        else if (cur > goal)
        begin
            ramp_to = (dn[15:0] < goal || dn[16]) ? goal : dn[15:0];
        end
        else
        begin
            ramp_to = cur;
        end
    endfunction

    function automatic logic [15:0] speed_pick(input logic [15:0] top, input logic [3:0] sel);
        logic [31:0] p;
        p = 32'(top) * 32'(sel);
        speed_pick = (sel == 4'h0) ? top : p[19:4];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    smmc_input_pol u_pol
    (
        .clk (CLK_SYS),
        .rst (SYS_RST),
        .ce  (CLK_EN),
        .raw (IN_RAW),
        .pol (CFG.in_pol),
        .act (act)
    );

    smmc_step_gen u_gen
    (
        .clk  (CLK_SYS),
        .rst  (SYS_RST),
        .ce   (CLK_EN),
        .hz   (gen_hz),
        .step (gen_step)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_state    = state;
        next_pos      = pos;
        next_tgt      = tgt;
        next_hz       = cur_hz;
        next_dir      = DIR;
        next_ref_done = ref_done;
        next_step     = 1'b0;
        gen_hz        = smmc_pkg::RST_HZ;
        want          = 1'b0;
        run_hz        = smmc_pkg::RST_HZ;
        ramp_now      = (tick == RAMP_TICK_CYC - 32'h0000_0001);
        next_tick     = ramp_now ? 32'h0000_0000 : tick + 32'h0000_0001;
        next_gap      = (gap < smmc_pkg::CD_MIN_GAP_CYC) ? gap + 16'h0001 : gap;
        is_cd         = CFG.mode inside {smmc_pkg::MD_CD_LEFT, smmc_pkg::MD_CD_RIGHT,
                                         smmc_pkg::MD_CD_IREF, smmc_pkg::MD_CD_EREF};
        no_ramp       = CFG.mode inside {smmc_pkg::MD_IREF, smmc_pkg::MD_CD_IREF};
        mag           = smmc_pkg::analog_mag(ANALOG_IN);
        next_torque   = (CFG.mode == smmc_pkg::MD_TORQUE) ? mag : smmc_pkg::TORQUE_FULL;
        next_match    = FRAME_ADDR_VALID && FRAME_ADDR == NODE_ADDR &&
                        NODE_ADDR >= smmc_pkg::ADDR_MIN && NODE_ADDR <= smmc_pkg::ADDR_MAX;

        case (state)
            smmc_pkg::ST_IDLE:
            begin
                if (START)
                begin
                    next_hz       = CFG.start_hz;
                    next_ref_done = 1'b0;
                    case (CFG.mode)
                        smmc_pkg::MD_REL:
                        begin
                            next_tgt   = pos + CFG.target;
                            next_state = smmc_pkg::ST_POS;
                        end
                        smmc_pkg::MD_ABS:
                        begin
                            next_tgt   = CFG.target;
                            next_state = smmc_pkg::ST_POS;
                        end
                        smmc_pkg::MD_IREF, smmc_pkg::MD_CD_IREF:
                        begin
                            next_tgt   = smmc_pkg::RST_POS;
                            next_state = smmc_pkg::ST_POS;
                        end
                        smmc_pkg::MD_EREF, smmc_pkg::MD_CD_EREF:
                        begin
                            next_state = smmc_pkg::ST_REF;
                        end
                        smmc_pkg::MD_APOS:
                        begin
                            next_state = smmc_pkg::ST_POS;
                        end
                        default:
                        begin
                            next_state = smmc_pkg::ST_RUN;
                        end
                    endcase
                end
            end

            smmc_pkg::ST_REF:
            begin
                next_dir = CFG.ref_dir;
                if (act[is_cd ? smmc_pkg::IN_CDLIM : smmc_pkg::IN_SW])
                begin
                    next_pos      = smmc_pkg::RST_POS;
                    next_ref_done = 1'b1;
                    next_state    = is_cd ? smmc_pkg::ST_RUN : smmc_pkg::ST_IDLE;
                end
                else
                begin
                    gen_hz = CFG.start_hz;
                    want   = gen_step;
                end
            end

            smmc_pkg::ST_POS:
            begin
                if (CFG.mode == smmc_pkg::MD_APOS)
                begin
                    next_tgt = 32'(ANALOG_IN) <<< smmc_pkg::APOS_SHIFT;
                end
                if (pos == tgt && CFG.mode != smmc_pkg::MD_APOS)
                begin
                    next_ref_done = no_ramp ? 1'b1 : ref_done;
                    next_state    = is_cd ? smmc_pkg::ST_RUN : smmc_pkg::ST_IDLE;
                end
                else if (pos != tgt)
                begin
                    next_dir = (tgt > pos);
                    if (no_ramp)
                    begin
                        next_hz = CFG.start_hz;
                    end
                    else if (ramp_now)
                    begin
                        next_hz = ramp_to(cur_hz, CFG.max_hz, CFG.ramp_hz);
                    end
                    gen_hz = cur_hz;
                    want   = gen_step;
                end
            end

            smmc_pkg::ST_RUN:
            begin
                if (is_cd)
                begin
                    if (act[smmc_pkg::IN_SW] && !cd_clk_q && act[smmc_pkg::IN_EN] &&
                        gap >= smmc_pkg::CD_MIN_GAP_CYC)
                    begin
                        next_dir = (CFG.mode == smmc_pkg::MD_CD_LEFT) ? !act[smmc_pkg::IN_CDDIR]
                                                                      : act[smmc_pkg::IN_CDDIR];
                        want     = 1'b1;
                        next_gap = 16'h0000;
                    end
                end
                else
                begin
                    case (CFG.mode)
                        smmc_pkg::MD_SPEED:
                        begin
                            run_hz   = speed_pick(CFG.max_hz, act[4:1]);
                            next_dir = act[smmc_pkg::IN_SW];
                        end
                        smmc_pkg::MD_FLAG:
                        begin
                            run_hz   = CFG.max_hz;
                            next_dir = !CFG.target[31];
                            if (act[smmc_pkg::IN_TRIG] && !trig_q)
                            begin
                                next_tgt   = pos + CFG.target;
                                next_state = smmc_pkg::ST_POS;
                            end
                        end
                        smmc_pkg::MD_ANALOG, smmc_pkg::MD_JOY:
                        begin
                            run_hz   = (CFG.mode == smmc_pkg::MD_JOY && mag < smmc_pkg::JOY_DEAD)
                                       ? smmc_pkg::RST_HZ
                                       : 16'(32'(mag) * 32'(smmc_pkg::ANALOG_HZ_GAIN));
                            next_dir = !ANALOG_IN[11];
                        end
                        default:
                        begin
                            run_hz   = CFG.max_hz;
                            next_dir = act[smmc_pkg::IN_SW];
                        end
                    endcase
                    if (CFG.mode != smmc_pkg::MD_FLAG && !act[smmc_pkg::IN_EN])
                    begin
                        next_hz = CFG.start_hz;
                    end
                    else
                    begin
                        if (ramp_now)
                        begin
                            next_hz = ramp_to(cur_hz, smmc_pkg::clamp_hz(run_hz), CFG.ramp_hz);
                        end
                        gen_hz = (run_hz == smmc_pkg::RST_HZ) ? smmc_pkg::RST_HZ : cur_hz;
                        want   = gen_step;
                    end
                end
            end

            default:
            begin
                next_state = smmc_pkg::ST_IDLE;
            end
        endcase

        if (STOP)
        begin
            next_state = smmc_pkg::ST_IDLE;
            want       = 1'b0;
        end

        if (want)
        begin
            next_step = 1'b1;
            next_pos  = next_dir ? next_pos + 32'sh0000_0001 : next_pos - 32'sh0000_0001;
        end
    end


    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            state    <= smmc_pkg::ST_IDLE;
            pos      <= smmc_pkg::RST_POS;
            tgt      <= smmc_pkg::RST_POS;
            cur_hz   <= smmc_pkg::RST_HZ;
            tick     <= 32'h0000_0000;
            gap      <= 16'h0000;
            DIR      <= 1'b0;
            STEP     <= 1'b0;
            ref_done <= 1'b0;
            cd_clk_q <= 1'b0;
            trig_q   <= 1'b0;
            torque   <= smmc_pkg::TORQUE_FULL;
            ADDR_MATCH <= 1'b0;
        end
        else if (CLK_EN)
        begin
            state    <= next_state;
            pos      <= next_pos;
            tgt      <= next_tgt;
            cur_hz   <= next_hz;
            tick     <= next_tick;
            gap      <= next_gap;
            DIR      <= next_dir;
            STEP     <= next_step;
            ref_done <= next_ref_done;
            cd_clk_q <= act[smmc_pkg::IN_SW];
            trig_q   <= act[smmc_pkg::IN_TRIG];
            torque   <= next_torque;
            ADDR_MATCH <= next_match;
        end
    end

    always_comb
    begin
        STATUS.busy         = (state != smmc_pkg::ST_IDLE);
        STATUS.ref_done     = ref_done;
        STATUS.position     = pos;
        STATUS.torque_limit = torque;
    end
endmodule // smmc_top
`default_nettype wire

// file: verification/smmc_assertions.sv
// assertion checker for the motion mode controller
`timescale 1ns/1ps
`default_nettype none
module smmc_checker
#(
    parameter int unsigned RAMP_TICK_CYC = 8
)
(
    input wire logic                 CLK_SYS,
    input wire logic                 SYS_RST,
    input wire logic                 CLK_EN,
    input wire logic                 START,
    input wire logic                 STOP,
    input wire smmc_pkg::smmc_cfg_s  CFG,
    input wire logic [5:0]           IN_RAW,
    input wire logic signed [11:0]   ANALOG_IN,
    input wire logic [7:0]           NODE_ADDR,
    input wire logic [7:0]           FRAME_ADDR,
    input wire logic                 FRAME_ADDR_VALID,
    input wire logic                 STEP,
    input wire logic                 DIR,
    input wire smmc_pkg::smmc_stat_s STATUS,
    input wire logic                 ADDR_MATCH
);
    logic hit;
    assign hit = FRAME_ADDR_VALID && CLK_EN && FRAME_ADDR == NODE_ADDR && NODE_ADDR != 8'h00 && NODE_ADDR != 8'hFF;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    ////////////////////////////////////////////////////////////
    sequence quiet8;
        !STEP [*8];
    endsequence
    sequence took_start;
        START && CLK_EN && !STOP && !STATUS.busy;
    endsequence
    a_step_gap: assert property (STEP |=> quiet8)
        else $error("step pulses too close");
    a_step_up: assert property ($rose(STEP) && DIR |-> STATUS.position == $past(STATUS.position) + 32'sh0000_0001)
        else $error("position not incremented");
    a_step_down: assert property ($rose(STEP) && !DIR |-> STATUS.position == $past(STATUS.position) - 32'sh0000_0001)
        else $error("position not decremented");
    a_pos_hold: assert property (!STEP && !$rose(STATUS.ref_done) |-> $stable(STATUS.position))
        else $error("position moved without a step");
    a_start_busy: assert property (took_start |=> STATUS.busy)
        else $error("start not taken");
    a_stop_idle: assert property (STOP && CLK_EN |=> !STATUS.busy && !STEP)
        else $error("stop did not return to idle");
    a_addr_hit: assert property (hit |=> ADDR_MATCH)
        else $error("own address missed");
    a_addr_miss: assert property (ADDR_MATCH |-> $past(hit))
        else $error("match without own address");
endmodule // smmc_checker
`default_nettype wire

// file: verification/smmc_indexer.sv
// step and direction indexer driving the clock-direction inputs
`timescale 1ns/1ps
`default_nettype none
module smmc_indexer
#(
    parameter int GAP = 500
)
(
    input  wire logic       clk,
    input  wire logic       req,
    input  wire logic       dir,
    input  wire logic [7:0] count,
    output var  logic       step_clk,
    output var  logic       step_dir,
    output var  logic       done
);
    initial
    begin
        step_clk = 1'b0;
        step_dir = 1'b0;
        done = 1'b1;
    end
    always
    begin
        @(posedge clk iff req);
        @(negedge clk);
        done = 1'b0;
        step_dir = dir;
        repeat (count)
        begin
            step_clk = 1'b1;
            repeat (4) @(negedge clk);
            step_clk = 1'b0;
            repeat (GAP) @(negedge clk);
        end
        done = 1'b1;
    end
endmodule // smmc_indexer
`default_nettype wire

// file: verification/tb_top.sv
// self-checking bench for the motion mode controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic                 clk_sys = 1'b0;
    logic                 sys_rst = 1'b1;
    logic                 start = 1'b0;
    logic                 stop = 1'b0;
    smmc_pkg::smmc_cfg_s  cfg = '0;
    logic [3:0]           raw_lo = 4'h0;
    logic signed [11:0]   analog = 12'sh000;
    logic [7:0]           node = 8'h00;
    logic [7:0]           faddr = 8'h00;
    logic                 fvalid = 1'b0;
    logic                 clk_en = 1'b1;
    logic                 idx_req = 1'b0;
    logic                 idx_dir = 1'b0;
    logic [7:0]           idx_n = 8'h00;
    logic                 idx_clk, idx_line, idx_done, step, dir, amatch;
    smmc_pkg::smmc_stat_s stat;
    int                   fail_count = 0;
    int                   checks = 0;
    int                   seed = 40;
    int                   steps = 0;
    logic [31:0]          exp_q[$];
    logic [31:0]          got, e_now;
    logic [31:0]          held;
    logic [11:0]          mag;
    logic [7:0]           addr_tab[8] = '{8'h00, 8'h01, 8'h2A, 8'h5C, 8'hFF, 8'h77, 8'hFE, 8'h10};
    event                 seen;

    always #25 clk_sys = ~clk_sys;
    // step pulses seen on the output pin
    always @(negedge clk_sys)
        steps += int'(step === 1'b1);

    smmc_top #(.RAMP_TICK_CYC(8)) dut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .CLK_EN(clk_en), .START(start),
        .STOP(stop), .CFG(cfg), .IN_RAW({idx_clk, idx_line, raw_lo}), .ANALOG_IN(analog), .NODE_ADDR(node),
        .FRAME_ADDR(faddr), .FRAME_ADDR_VALID(fvalid), .STEP(step), .DIR(dir), .STATUS(stat), .ADDR_MATCH(amatch));
    smmc_indexer #(.GAP(500)) u_idx (.clk(clk_sys), .req(idx_req), .dir(idx_dir), .count(idx_n),
        .step_clk(idx_clk), .step_dir(idx_line), .done(idx_done));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] e, input logic [31:0] a);
        exp_q.push_back(e);
        got = a;
        -> seen;
        #1;
    endtask
    always @(seen)
    begin
        e_now = exp_q.pop_front();
        checks++;
        if (e_now !== got)
        begin
            $display("mismatch at %0t: expected %h got %h", $time, e_now, got);
            fail_count++;
        end
    end
    task automatic pulse(ref logic s);
        @(negedge clk_sys);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
    endtask
    task automatic move(input smmc_pkg::smmc_mode_e m, input logic signed [31:0] t);
        cfg.mode = m;
        cfg.target = t;
        pulse(start);
        for (int i = 0; i < 20000 && stat.busy !== 1'b0 && m < smmc_pkg::MD_EREF; i++) @(negedge clk_sys);
        if (m < smmc_pkg::MD_EREF)
            chk(32'h0000_0000, 32'(stat.busy));
    endtask
    task automatic index(input logic d, input logic [7:0] n);
        idx_dir = d;
        idx_n = n;
        pulse(idx_req);
        repeat (3) @(negedge clk_sys);
        for (int i = 0; i < 20000 && idx_done !== 1'b1; i++) @(negedge clk_sys);
        repeat (5) @(negedge clk_sys);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        cfg = '{smmc_pkg::MD_REL, 16'h61A8, 16'h61A8, 16'h0000, 32'sh0000_0000, 1'b1, 6'h3F};
        repeat (3) @(negedge clk_sys);
        sys_rst = 1'b0;
        chk(32'h0000_0FFF, 32'(stat.torque_limit));
        chk(32'h0000_0000, stat.position);
        $display("test reset done");
        foreach (addr_tab[i])
        begin
            @(negedge clk_sys);
            node = addr_tab[i];
            faddr = addr_tab[i] ^ {7'h00, i[0]};
            fvalid = 1'b1;
            @(negedge clk_sys);
            fvalid = 1'b0;
            chk(32'(!i[0] && addr_tab[i] inside {[8'h01:8'hFE]}), 32'(amatch));
        end
        $display("test address done");
        move(smmc_pkg::MD_REL, 32'sh0000_0003);
        chk(32'h0000_0003, stat.position);
        move(smmc_pkg::MD_ABS, -32'sh0000_0002);
        chk(32'hFFFF_FFFE, stat.position);
        $display("test positioning done");
        cfg.in_pol = 6'h3E;
        move(smmc_pkg::MD_CD_RIGHT, 32'sh0000_0000);
        index(1'b1, 8'h05);
        chk(32'h0000_0001, 32'(dir));
        index(1'b0, 8'h02);
        chk(32'h0000_0001, stat.position);
        raw_lo = 4'h1;
        index(1'b1, 8'h02);
        chk(32'h0000_0001, stat.position);
        pulse(stop);
        chk(32'h0000_0000, 32'(stat.busy));
        chk(32'h0000_000F, 32'(steps));
        $display("test clock direction done");
        move(smmc_pkg::MD_IREF, 32'sh0000_0000);
        chk(32'h0000_0000, stat.position);
        chk(32'h0000_0001, 32'(stat.ref_done));
        move(smmc_pkg::MD_EREF, 32'sh0000_0000);
        repeat (2000) @(negedge clk_sys);
        @(negedge clk_sys iff (step === 1'b0));
        held = stat.position;
        clk_en = 1'b0;
        repeat (1000) @(negedge clk_sys);
        chk(held, stat.position);
        clk_en = 1'b1;
        index(1'b1, 8'h01);
        chk(32'h0000_0000, stat.position);
        chk(32'h0000_0001, 32'(stat.ref_done));
        chk(32'h0000_0000, 32'(stat.busy));
        $display("test reference done");
        analog = 12'($random(seed));
        mag = analog[11] ? 12'(-analog) : 12'(analog);
        move(smmc_pkg::MD_TORQUE, 32'sh0000_0000);
        repeat (4) @(negedge clk_sys);
        chk(32'(mag), 32'(stat.torque_limit));
        pulse(stop);
        $display("test torque done");
        wrap_up();
    end
    initial
    begin
        #(40000 * 50);
        fail_count++;
        wrap_up();
    end
endmodule // tb_top

bind smmc_top smmc_checker #(.RAMP_TICK_CYC(RAMP_TICK_CYC)) u_chk (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
    .CLK_EN(CLK_EN), .START(START), .STOP(STOP), .CFG(CFG), .IN_RAW(IN_RAW), .ANALOG_IN(ANALOG_IN),
    .NODE_ADDR(NODE_ADDR), .FRAME_ADDR(FRAME_ADDR), .FRAME_ADDR_VALID(FRAME_ADDR_VALID), .STEP(STEP),
    .DIR(DIR), .STATUS(STATUS), .ADDR_MATCH(ADDR_MATCH));
`default_nettype wire
